// ---- core/epp_host_port_rev17.sv ----
// enhanced parallel port, host-side register set and revision 1.7 cycle logic
// assumes a host bus with active-low read and write strobes that waits on BUS_READY,
// and a peripheral on the parallel connector; the bus and connector pins are synchronised here, EPP_ENABLE is used as it comes
//
// Overview of operation
// - without EPP access, behave as SPP Extended
// - ready held low too long raises time-out
// - time-out counts only while device clock runs
// - time-out releases strobe, sets status bit 0
// - time-out pulses interrupt when enable bit set
// - address register access starts address cycle
// - data register 0 access starts data cycle
// - data register 1 carries bits 15..8
// - data registers 2, 3 carry upper bytes
// - SPP data write sets port data lines
// - status read-only: pins plus interrupt status
// - control write sets pins, irq enable, direction
// - address write: latch, drive, write low, strobe
// - wait low pulls ready low until high
// - write end: strobe rises, then write line
// - address read gates port data, strobe low
// - read end: strobe rises and bus floats in the same cycle
// - data cycles mirror address cycles, data strobe
// - time-out flag cleared on enable, status read
`include "epp_consts.svh"

module epp_host_port_rev17
   import epp_pkg::*;
#(
   parameter int TIMEOUT_CYC = `EPP_TMO_CYC
)
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        EPP_ENABLE,
   input  wire logic        HOST_RD_N,
   input  wire logic        HOST_WR_N,
   input  wire logic [2:0]  HOST_ADDR,
   input  wire logic [1:0]  XFER_SIZE,
   input  wire logic [31:0] HOST_DATA_I,
   output logic      [31:0] HOST_DATA_O,
   output logic             HOST_DATA_OE,
   output logic             BUS_READY,
   output logic             PORT_IRQ,
   input  wire logic [7:0]  PORT_DATA_I,
   output logic      [7:0]  PORT_DATA_O,
   output logic             PORT_DATA_OE,
   output logic             PORT_STROBE_N,
   output logic             PORT_AUTOFD_N,
   output logic             PORT_INIT_N,
   output logic             PORT_SELECT_IN_N,
   input  wire logic        PORT_WAIT_BUSY,
   input  wire logic        PORT_ACK_N,
   input  wire logic        PORT_PE,
   input  wire logic        PORT_SLCT,
   input  wire logic        PORT_ERR_N
);

   // =======================================================================
   // elaboration check
   generate
      if (TIMEOUT_CYC < 1 || TIMEOUT_CYC > 65534)
      begin : g_bad_timeout
         $error("epp_host_port_rev17: TIMEOUT_CYC out of range");
      end
   endgenerate

   core_s q;
   core_s d;
   pins_s pins;
   logic  expired;

   // =======================================================================
   // time-out counter, running while the host is held off
   epp_timeout_counter #(
      .LIMIT   (TIMEOUT_CYC)
   ) u_tmo (
      .CLK     (CLK),
      .RST_N   (RST_N),
      .RUN     (!q.ready && q.fsm != S_IDLE),
      .EXPIRED (expired)
   );

   // =======================================================================
   // pin sampling; the wait input shares the busy pin
   always_comb
   begin
      pins.rd_n   = HOST_RD_N;
      pins.wr_n   = HOST_WR_N;
      pins.addr   = HOST_ADDR;
      pins.size   = XFER_SIZE;
      pins.hdata  = HOST_DATA_I;
      pins.wait_n = PORT_WAIT_BUSY;
      pins.pd     = PORT_DATA_I;
      pins.busy   = PORT_WAIT_BUSY;
      pins.ack_n  = PORT_ACK_N;
      pins.pe     = PORT_PE;
      pins.slct   = PORT_SLCT;
      pins.err_n  = PORT_ERR_N;
   end

   // =======================================================================
   // next state
   always_comb
   begin
      pins_s      p;
      pins_s      pp;
      logic       wr_fall;
      logic       rd_fall;
      logic       rd_rise;
      logic       host_idle;
      logic       epp_reg;
      logic       start;
      logic [4:0] bsel;
      logic [7:0] rdata;
      d = q;
      p = q.s2;
      pp = q.s3;
      wr_fall = pp.wr_n && !p.wr_n;
      rd_fall = pp.rd_n && !p.rd_n;
      rd_rise = !pp.rd_n && p.rd_n;
      host_idle = p.rd_n && p.wr_n;
      epp_reg = EPP_ENABLE && (p.addr == `OFS_EPP_ADDRESS || p.addr == `OFS_EPP_EPP_DATA_BYTE0);
      start = 1'b0;
      bsel = {q.idx, 3'h0};
      rdata = 8'h00;
      d.s1 = pins;
      d.s2 = q.s1;
      d.s3 = q.s2;
      d.irq = 1'b0;
      d.en_prev = EPP_ENABLE;

      // status bits; the clears come first so that a set in the same cycle wins
      if (EPP_ENABLE && !q.en_prev)
      begin
         d.tmo_flag = 1'b0;
      end
      if (q.fsm == S_IDLE && rd_rise && pp.addr == `OFS_PORT_STATUS)
      begin
         d.tmo_flag = 1'b0;
         d.irq_stat = 1'b1;
      end
      if (!pp.ack_n && p.ack_n && q.ctrl[`CTL_IRQ_EN_BIT])
      begin
         // interrupt is a pulse here, the latched copy sits in status bit 2
         d.irq = 1'b1;
         d.irq_stat = 1'b0;
      end

      // register read data
      unique case (p.addr)
         `OFS_SPP_DATA:     rdata = q.ctrl[`CTL_DIR_BIT] ? p.pd : q.spp_data;
         `OFS_PORT_STATUS:  rdata = {!p.busy, p.ack_n, p.pe, p.slct, p.err_n, q.irq_stat,
                                     1'b1, EPP_ENABLE ? q.tmo_flag : 1'b1};
         `OFS_PORT_CONTROL: rdata = {`CTL_RSVD_READ, EPP_ENABLE ? q.ctrl[`CTL_DIR_BIT] : 1'b1,
                                     q.ctrl[4:0]};
         `OFS_EPP_ADDRESS:  rdata = q.addr_byte;
         `OFS_EPP_EPP_DATA_BYTE0:    rdata = q.bytes[7:0];
         `OFS_EPP_EPP_DATA_BYTE1:    rdata = q.bytes[15:8];
         `OFS_EPP_EPP_DATA_BYTE2:    rdata = q.bytes[23:16];
         `OFS_EPP_EPP_DATA_BYTE3:    rdata = q.bytes[31:24];
      endcase

      unique case (q.fsm)
         S_IDLE:
         begin
            d.hdata_oe = !p.rd_n;
            d.hdata_o = {24'h000000, rdata};
            if ((wr_fall || rd_fall) && epp_reg)
            begin
               start = 1'b1;
            end
            else if (wr_fall)
            begin
               // writes to status are ignored
               unique case (p.addr)
                  `OFS_SPP_DATA:     d.spp_data = p.hdata[7:0];
                  `OFS_PORT_CONTROL: d.ctrl = p.hdata[7:0];
                  `OFS_EPP_ADDRESS:  d.addr_byte = p.hdata[7:0];
                  `OFS_EPP_EPP_DATA_BYTE0:    d.bytes[7:0] = p.hdata[7:0];
                  `OFS_EPP_EPP_DATA_BYTE1:    d.bytes[15:8] = p.hdata[7:0];
                  `OFS_EPP_EPP_DATA_BYTE2:    d.bytes[23:16] = p.hdata[7:0];
                  `OFS_EPP_EPP_DATA_BYTE3:    d.bytes[31:24] = p.hdata[7:0];
                  default:           d.spp_data = q.spp_data;
               endcase
            end
            if (start)
            begin
               d.write_cyc = !p.wr_n;
               d.addr_cyc = (p.addr == `OFS_EPP_ADDRESS);
               d.idx = 2'h0;
               // a reserved size code runs as a 16-bit transfer
               d.last = d.addr_cyc ? `XFER_8 :
                        (p.size == `XFER_RSVD ? `XFER_16 : p.size);
               if (!p.wr_n && d.addr_cyc)
               begin
                  d.addr_byte = p.hdata[7:0];
               end
               else if (!p.wr_n)
               begin
                  d.bytes = p.hdata;
               end
               d.write_n = p.wr_n;
               d.ready = p.wait_n && d.last == `XFER_8;
               d.hdata_oe = 1'b0;
               d.fsm = S_DRIVE;
            end
         end
         S_DRIVE:
         begin
            if (q.addr_cyc)
            begin
               d.addr_strobe_n = 1'b0;
            end
            else
            begin
               d.data_strobe_n = 1'b0;
            end
            d.fsm = S_STROBE;
         end
         S_STROBE:
         begin
            if (!q.write_cyc && q.addr_cyc)
            begin
               d.addr_byte = p.pd;
            end
            else if (!q.write_cyc)
            begin
               d.bytes[bsel +: 8] = p.pd;
            end
            if (expired)
            begin
               d.fsm = S_ABORT;
            end
            else if (p.wait_n && q.idx != q.last)
            begin
               d.addr_strobe_n = 1'b1;
               d.data_strobe_n = 1'b1;
               d.write_n = 1'b1;
               d.fsm = S_GAP;
            end
            else if (p.wait_n)
            begin
               d.ready = 1'b1;
               d.fsm = S_HOLD;
            end
         end
         S_GAP:
         begin
            // next byte only once the peripheral has dropped its acknowledge
            if (expired)
            begin
               d.fsm = S_ABORT;
            end
            else if (!p.wait_n)
            begin
               d.idx = q.idx + 2'h1;
               d.write_n = !q.write_cyc;
               d.fsm = S_DRIVE;
            end
         end
         S_HOLD:
         begin
            if (host_idle)
            begin
               d.addr_strobe_n = 1'b1;
               d.data_strobe_n = 1'b1;
               d.fsm = S_END;
            end
         end
         S_ABORT:
         begin
            if (host_idle)
            begin
               d.fsm = S_END;
            end
         end
         S_END:
         begin
            d.write_n = 1'b1;
            d.hdata_oe = 1'b0;
            d.fsm = S_IDLE;
         end
      endcase

      // time-out abort, entered from a stalled strobe or gap
      if (d.fsm == S_ABORT && q.fsm != S_ABORT)
      begin
         d.addr_strobe_n = 1'b1;
         d.data_strobe_n = 1'b1;
         d.ready = 1'b1;
         d.tmo_flag = 1'b1;
         d.irq = q.ctrl[`CTL_IRQ_EN_BIT];
      end

      // host bus during an EPP read: live port data until wait is seen high, then held until the host releases read
      if (q.fsm != S_IDLE && q.fsm != S_END && !q.write_cyc)
      begin
         d.hdata_oe = !p.rd_n || q.fsm != S_HOLD;
         d.hdata_o = q.addr_cyc ? {24'h000000, d.addr_byte} : d.bytes;
      end

      // port data lines; during an EPP cycle the sequencer owns them
      if (d.fsm != S_IDLE && d.write_cyc)
      begin
         d.pd_o = d.addr_cyc ? d.addr_byte : d.bytes[{d.idx, 3'h0} +: 8];
         d.pd_oe = 1'b1;
      end
      else if (d.fsm != S_IDLE)
      begin
         d.pd_o = d.spp_data;
         d.pd_oe = 1'b0;
      end
      else
      begin
         d.pd_o = d.spp_data;
         d.pd_oe = !d.ctrl[`CTL_DIR_BIT];
      end

      // control pins; bits left set by software would mask the hardware strobes
      d.stb_n = d.write_n && !d.ctrl[`CTL_STROBE_BIT];
      d.afd_n = d.data_strobe_n && !d.ctrl[`CTL_AUTOFD_BIT];
      d.init_n = d.ctrl[`CTL_INIT_BIT];
      d.slin_n = d.addr_strobe_n && !d.ctrl[`CTL_SELIN_BIT];
   end

   // =======================================================================
   // state register; sampled pins reset to their idle levels
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         q <= '0;
         q.s1.rd_n <= 1'b1;
         q.s1.wr_n <= 1'b1;
         q.s1.ack_n <= 1'b1;
         q.s2.rd_n <= 1'b1;
         q.s2.wr_n <= 1'b1;
         q.s2.ack_n <= 1'b1;
         q.s3.rd_n <= 1'b1;
         q.s3.wr_n <= 1'b1;
         q.s3.ack_n <= 1'b1;
         q.fsm <= S_IDLE;
         q.ctrl <= `CTL_RST;
         q.tmo_flag <= 1'b1;
         q.irq_stat <= 1'b1;
         q.write_n <= 1'b1;
         q.addr_strobe_n <= 1'b1;
         q.data_strobe_n <= 1'b1;
         q.pd_oe <= 1'b1;
         q.stb_n <= 1'b1;
         q.afd_n <= 1'b1;
         q.init_n <= 1'b1;
         q.slin_n <= 1'b1;
         q.ready <= 1'b1;
      end
      else
      begin
         q <= d;
      end
   end

   // =======================================================================
   // outputs, all straight from the state register
   assign HOST_DATA_O      = q.hdata_o;
   assign HOST_DATA_OE     = q.hdata_oe;
   assign BUS_READY        = q.ready;
   assign PORT_IRQ         = q.irq;
   assign PORT_DATA_O      = q.pd_o;
   assign PORT_DATA_OE     = q.pd_oe;
   assign PORT_STROBE_N    = q.stb_n;
   assign PORT_AUTOFD_N    = q.afd_n;
   assign PORT_INIT_N      = q.init_n;
   assign PORT_SELECT_IN_N = q.slin_n;

endmodule : epp_host_port_rev17

// ---- core/epp_timeout_counter.sv ----
// time-out counter for a stalled peripheral cycle
// assumes RUN is a same-clock level that is high while bus ready is held low
`include "epp_consts.svh"

module epp_timeout_counter
   import epp_pkg::*;
#(
   parameter int LIMIT = `EPP_TMO_CYC
)
(
   input  wire logic CLK,
   input  wire logic RST_N,
   input  wire logic RUN,
   output logic      EXPIRED
);

   // =======================================================================
   // elaboration check
   generate
      if (LIMIT < 1 || LIMIT > 65534)
      begin : g_bad_limit
         $error("epp_timeout_counter: LIMIT out of range");
      end
   endgenerate

   localparam logic [15:0] LIMIT_C = 16'(LIMIT);

   tmo_s q;
   tmo_s d;

   // =======================================================================
   // counting; a stopped clock counts nothing, so no time-out is raised then
   always_comb
   begin
      d = q;
      d.expired = 1'b0;
      if (!RUN)
      begin
         d.cnt = 16'h0000;
      end
      else if (q.cnt == LIMIT_C)
      begin
         d.expired = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign EXPIRED = q.expired;

endmodule : epp_timeout_counter

// ---- pkg/epp_consts.svh ----
// register offsets, field positions, reset values and timing counts of the enhanced parallel port
// assumes inclusion by bare name from the package and the design modules
`ifndef EPP_CONSTS_SVH
`define EPP_CONSTS_SVH

// ==========================================================================
// register offsets (host address lines A2..A0)
`define OFS_SPP_DATA        3'h0
`define OFS_PORT_STATUS     3'h1
`define OFS_PORT_CONTROL    3'h2
`define OFS_EPP_ADDRESS     3'h3
`define OFS_EPP_EPP_DATA_BYTE0       3'h4
`define OFS_EPP_EPP_DATA_BYTE1       3'h5
`define OFS_EPP_EPP_DATA_BYTE2       3'h6
`define OFS_EPP_EPP_DATA_BYTE3       3'h7

// ==========================================================================
// control register fields
`define CTL_STROBE_BIT      0
`define CTL_AUTOFD_BIT      1
`define CTL_INIT_BIT        2
`define CTL_SELIN_BIT       3
`define CTL_IRQ_EN_BIT      4
`define CTL_DIR_BIT         5
`define CTL_RST             8'h04
`define CTL_RSVD_READ       2'h3

// ==========================================================================
// transfer size codes on XFER_SIZE; except for the reserved code, the code is the index of the last byte
`define XFER_8              2'h0
`define XFER_16             2'h1
`define XFER_RSVD           2'h2
`define XFER_32             2'h3

// ==========================================================================
// timing
`define CLK_MHZ             250
`define EPP_TMO_NS          10000
`define EPP_TMO_CYC         ((`EPP_TMO_NS * `CLK_MHZ + 999) / 1000)

`endif

// ---- pkg/epp_pkg.sv ----
// types shared by the enhanced parallel port host-side logic
// assumes epp_consts.svh is on the include path
`include "epp_consts.svh"

package epp_pkg;

   // =======================================================================
   // pin bundle sampled from outside the clock domain
   typedef struct packed {
      logic        rd_n;
      logic        wr_n;
      logic [2:0]  addr;
      logic [1:0]  size;
      logic [31:0] hdata;
      logic        wait_n;
      logic [7:0]  pd;
      logic        busy;
      logic        ack_n;
      logic        pe;
      logic        slct;
      logic        err_n;
   } pins_s;

   // =======================================================================
   // peripheral cycle sequencer
   typedef enum logic [2:0] {
      S_IDLE,
      S_DRIVE,
      S_STROBE,
      S_GAP,
      S_HOLD,
      S_ABORT,
      S_END
   } epp_fsm_e;

   typedef struct packed {
      pins_s       s1;
      pins_s       s2;
      pins_s       s3;
      epp_fsm_e    fsm;
      logic        write_cyc;
      logic        addr_cyc;
      logic [1:0]  idx;
      logic [1:0]  last;
      logic [7:0]  spp_data;
      logic [7:0]  ctrl;
      logic [7:0]  addr_byte;
      logic [31:0] bytes;
      logic        tmo_flag;
      logic        irq_stat;
      logic        en_prev;
      logic        write_n;
      logic        addr_strobe_n;
      logic        data_strobe_n;
      logic [7:0]  pd_o;
      logic        pd_oe;
      logic        stb_n;
      logic        afd_n;
      logic        init_n;
      logic        slin_n;
      logic        ready;
      logic        irq;
      logic [31:0] hdata_o;
      logic        hdata_oe;
   } core_s;

   typedef struct packed {
      logic [15:0] cnt;
      logic        expired;
   } tmo_s;

endpackage : epp_pkg

// ---- tb/epp_host_port_properties.sv ----
// pin-level checks of the enhanced parallel port host side
// assumes it is bound into every instance of the host port top module
module epp_host_port_properties
#(
   parameter int TIMEOUT_CYC = 2500
)
(
   input wire logic       CLK,
   input wire logic       RST_N,
   input wire logic       EPP_ENABLE,
   input wire logic       HOST_RD_N,
   input wire logic       HOST_WR_N,
   input wire logic       HOST_DATA_OE,
   input wire logic       BUS_READY,
   input wire logic       PORT_IRQ,
   input wire logic [7:0] PORT_DATA_O,
   input wire logic       PORT_DATA_OE,
   input wire logic       PORT_STROBE_N,
   input wire logic       PORT_AUTOFD_N,
   input wire logic       PORT_SELECT_IN_N
);
   timeunit 1ns;
   timeprecision 1ps;
   int lowc_q;

   // =======================================================================
   // cycles the host has been held off in a row
   always_ff @(posedge CLK or negedge RST_N)
   begin
      if (!RST_N)
         lowc_q <= 0;
      else
         lowc_q <= BUS_READY ? 0 : lowc_q + 1;
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   sequence strobes_idle;
      PORT_SELECT_IN_N && PORT_AUTOFD_N;
   endsequence

   sequence tmo_release;
      $rose(BUS_READY) && lowc_q > TIMEOUT_CYC;
   endsequence

   chk_ready_cause: assert property ($fell(BUS_READY) |-> !(HOST_RD_N && HOST_WR_N))
      else $error("ready dropped with no host strobe low");
   chk_tmo_bound: assert property (lowc_q <= TIMEOUT_CYC + 3)
      else $error("ready held low past the time-out");
   chk_tmo_strobes: assert property (tmo_release |-> ##[0:1] strobes_idle)
      else $error("strobe still low after time-out");
   chk_irq_pulse: assert property (PORT_IRQ |=> !PORT_IRQ)
      else $error("interrupt longer than one cycle");
   chk_pd_stable: assert property (EPP_ENABLE && !$stable(PORT_DATA_O)
      |-> $past(PORT_SELECT_IN_N) && $past(PORT_AUTOFD_N))
      else $error("port data changed under a strobe");
   chk_write_order: assert property (EPP_ENABLE && $fell(PORT_SELECT_IN_N) && !PORT_STROBE_N
      |-> !$past(PORT_STROBE_N) && PORT_DATA_OE)
      else $error("address strobe before write line and data");
   chk_read_float: assert property (EPP_ENABLE && $fell(PORT_AUTOFD_N) && PORT_STROBE_N
      |-> !PORT_DATA_OE)
      else $error("port data driven during a read");
   chk_oe_release: assert property ($rose(HOST_RD_N) |-> ##[1:8] !HOST_DATA_OE)
      else $error("host data bus not floated");
   chk_float_after: assert property ($fell(HOST_DATA_OE) |-> strobes_idle)
      else $error("host bus floated before strobe rose");
   chk_strobe_excl: assert property (EPP_ENABLE |-> PORT_SELECT_IN_N || PORT_AUTOFD_N)
      else $error("both strobes low");
endmodule : epp_host_port_properties

bind epp_host_port_rev17 epp_host_port_properties #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (
   .CLK, .RST_N, .EPP_ENABLE, .HOST_RD_N, .HOST_WR_N, .HOST_DATA_OE, .BUS_READY,
   .PORT_IRQ, .PORT_DATA_O, .PORT_DATA_OE, .PORT_STROBE_N, .PORT_AUTOFD_N,
   .PORT_SELECT_IN_N
);

// ---- tb/epp_periph_model.sv ----
// behavioural peripheral on the parallel connector
// assumes write line and strobes come from registers on the same clock
module epp_periph_model
(
   input  wire logic       CLK,
   input  wire logic       ACT,
   input  wire logic       FAST,
   input  wire logic [7:0] LAG,
   input  wire logic [7:0] RD_BASE,
   input  wire logic       WR_N,
   input  wire logic       ASTB_N,
   input  wire logic       DSTB_N,
   input  wire logic [7:0] PD_O,
   output logic            WAIT_HI,
   output logic [7:0]      PD_I,
   output logic            GOT,
   output logic [8:0]      GOT_BYTE
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       stb_q = 0;
   logic       wr_q = 0;
   logic [7:0] rdn = 0;
   int         cnt = 0;
   int         idle = 0;
   wire        stb = ACT && !(ASTB_N && DSTB_N);

   initial
   begin
      WAIT_HI = 0;
      PD_I = 8'h5a;
      GOT = 0;
      GOT_BYTE = 0;
   end

   always @(posedge CLK)
   begin
      #1;
      stb_q <= stb;
      if (stb)
      begin
         GOT <= 1'b0;
         cnt <= cnt + 1;
         idle <= 0;
         wr_q <= !WR_N;
         // lag ff never answers, which leaves the host to its time-out
         WAIT_HI <= (LAG != 8'hff) && (cnt >= LAG);
         PD_I <= WR_N ? RD_BASE + rdn : ~PD_I;
         GOT_BYTE <= {!ASTB_N, PD_O};
      end
      else
      begin
         cnt <= 0;
         idle <= idle + 1;
         GOT <= stb_q && wr_q;
         if (stb_q && !wr_q)
            rdn <= rdn + 8'h1;
         WAIT_HI <= FAST && idle >= 6;
         // released lines never hold their last value
         PD_I <= ~PD_I;
      end
   end
endmodule : epp_periph_model

// ---- tb/tb.sv ----
// self-checking bench for the enhanced parallel port host side
// assumes the checker and the peripheral model are compiled first
`include "epp_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TMO = 100;
   logic        CLK = 0;
   logic        RST_N = 0;
   logic        EPP_ENABLE = 0;
   logic        HOST_RD_N = 1;
   logic        HOST_WR_N = 1;
   logic [2:0]  HOST_ADDR = 0;
   logic [1:0]  XFER_SIZE = 0;
   logic [31:0] HOST_DATA_I = 0;
   logic [31:0] HOST_DATA_O, hold, v, e, m, ew, mw;
   logic        HOST_DATA_OE, BUS_READY, PORT_IRQ, PORT_DATA_OE, PORT_WAIT_BUSY, got;
   logic        PORT_STROBE_N, PORT_AUTOFD_N, PORT_INIT_N, PORT_SELECT_IN_N;
   logic [7:0]  PORT_DATA_I, PORT_DATA_O;
   logic [8:0]  got_byte;
   logic [3:0]  st = 0;
   logic        fast = 0;
   logic        oe_q = 0;
   logic [7:0]  lag = 5;
   logic [7:0]  rd_base = 0;
   logic [7:0]  nrd = 0;
   logic [8:0]  wq[$];
   logic [31:0] rq[$];
   int          num_errors = 0, cmp_count = 0, irqs = 0, lc, nb, seed = 18607;

   always #2 CLK = ~CLK;

   epp_host_port_rev17 #(.TIMEOUT_CYC(TMO)) u_dut (
      .CLK, .RST_N, .EPP_ENABLE, .HOST_RD_N, .HOST_WR_N, .HOST_ADDR, .XFER_SIZE,
      .HOST_DATA_I, .HOST_DATA_O, .HOST_DATA_OE, .BUS_READY, .PORT_IRQ, .PORT_DATA_I,
      .PORT_DATA_O, .PORT_DATA_OE, .PORT_STROBE_N, .PORT_AUTOFD_N, .PORT_INIT_N,
      .PORT_SELECT_IN_N, .PORT_WAIT_BUSY, .PORT_ACK_N(st[3]), .PORT_PE(st[2]),
      .PORT_SLCT(st[1]), .PORT_ERR_N(st[0]));

   epp_periph_model u_periph (
      .CLK, .ACT(EPP_ENABLE), .FAST(fast), .LAG(lag), .RD_BASE(rd_base),
      .WR_N(PORT_STROBE_N), .ASTB_N(PORT_SELECT_IN_N), .DSTB_N(PORT_AUTOFD_N),
      .PD_O(PORT_DATA_O), .WAIT_HI(PORT_WAIT_BUSY), .PD_I(PORT_DATA_I), .GOT(got),
      .GOT_BYTE(got_byte));

   // =======================================================================
   // reporting
   task automatic end_sim();
      $display("comparisons %0d errors %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim

   task automatic check(input string what, input logic [31:0] ex, input logic [31:0] sn);
      cmp_count++;
      if (sn !== ex)
      begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, ex, sn);
      end
   endtask : check

   // =======================================================================
   // host bus: strobe held for at least 8 cycles and until ready is seen high
   task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] d,
                      input logic [1:0] sz, output int lowc);
      int n;
      lowc = 0;
      n = 0;
      HOST_ADDR = a;
      HOST_DATA_I = d;
      XFER_SIZE = sz;
      if (wr)
         HOST_WR_N = 0;
      else
         HOST_RD_N = 0;
      while (n < 8 || BUS_READY !== 1'b1)
      begin
         @(posedge CLK);
         n++;
         if (BUS_READY !== 1'b1)
            lowc++;
         if (n > 400)
         begin
            check("bus ready", 1, 0);
            end_sim();
         end
      end
      #1;
      HOST_WR_N = 1;
      HOST_RD_N = 1;
      repeat (10) @(posedge CLK);
      #1;
   endtask : acc

   task automatic rd(input logic [2:0] a, input logic [1:0] sz, input logic [31:0] ex,
                     input logic [31:0] mk);
      rq.push_back(ex & mk);
      rq.push_back(mk);
      acc(1'b0, a, 32'h0, sz, lc);
   endtask : rd

   function automatic logic [31:0] stat(input logic flag);
      return {24'h0, 1'b1, st, 2'b11, flag};
   endfunction : stat

   // =======================================================================
   // result watcher
   always @(posedge CLK)
   begin
      if (PORT_IRQ === 1'b1)
         irqs++;
      if (got === 1'b1)
      begin
         if (wq.size() == 0)
            check("stray port byte", 0, 1);
         else
            check("port byte", wq.pop_front(), got_byte);
      end
      if (HOST_DATA_OE === 1'b1 && HOST_RD_N === 1'b0)
         hold = HOST_DATA_O;
      if (HOST_DATA_OE !== 1'b1 && oe_q === 1'b1)
      begin
         if (rq.size() < 2)
            check("stray read", 0, 1);
         else
         begin
            ew = rq.pop_front();
            mw = rq.pop_front();
            check("host read", ew, hold & mw);
         end
      end
      oe_q = HOST_DATA_OE;
   end

   initial
   begin
      st = 4'($random(seed));
      rd_base = 8'($random(seed));
      repeat (20) @(posedge CLK);
      #1;
      RST_N = 1;
      repeat (2) @(posedge CLK);
      #1;
      acc(1'b1, `OFS_PORT_STATUS, 32'h0, `XFER_8, lc);
      rd(`OFS_PORT_STATUS, `XFER_8, stat(1'b1), '1);
      acc(1'b1, `OFS_PORT_CONTROL, 32'h0b, `XFER_8, lc);
      check("ctl pins", 0, {PORT_STROBE_N, PORT_AUTOFD_N, PORT_INIT_N, PORT_SELECT_IN_N});
      acc(1'b1, `OFS_PORT_CONTROL, `CTL_RST, `XFER_8, lc);
      check("ctl pins", 15, {PORT_STROBE_N, PORT_AUTOFD_N, PORT_INIT_N, PORT_SELECT_IN_N});
      EPP_ENABLE = 1;
      rd(`OFS_PORT_STATUS, `XFER_8, stat(1'b0), '1);
      v = $random(seed);
      acc(1'b1, `OFS_SPP_DATA, v, `XFER_8, lc);
      check("spp data", v[7:0], PORT_DATA_O);
      rd(`OFS_SPP_DATA, `XFER_8, v, 32'hff);
      for (int f = 0; f < 2; f++)
      begin
         fast = f[0];
         lag = f[0] ? 8'h0 : 8'h5;
         repeat (12) @(posedge CLK);
         #1;
         v = $random(seed);
         wq.push_back({1'b1, v[7:0]});
         acc(1'b1, `OFS_EPP_ADDRESS, v, `XFER_8, lc);
         check("ready held low", f[0] ? 0 : 1, lc > 0);
      end
      fast = 0;
      lag = 5;
      // sizes 0..3 written, then read; code 2 moves two bytes
      for (int s = 0; s < 8; s++)
      begin
         nb = (s[1:0] == 2'h3) ? 4 : (s[1:0] == 2'h0) ? 1 : 2;
         v = $random(seed);
         e = 0;
         m = 0;
         for (int k = 0; k < nb; k++)
         begin
            e[8*k +: 8] = rd_base + nrd + k[7:0];
            m[8*k +: 8] = 8'hff;
            if (s < 4)
               wq.push_back({1'b0, v[8*k +: 8]});
         end
         if (s < 4)
            acc(1'b1, `OFS_EPP_EPP_DATA_BYTE0, v, s[1:0], lc);
         else
         begin
            rd(`OFS_EPP_EPP_DATA_BYTE0, s[1:0], e, m);
            nrd = nrd + nb[7:0];
         end
      end
      rd(`OFS_EPP_ADDRESS, `XFER_8, {24'h0, rd_base + nrd}, 32'hff);
      acc(1'b1, `OFS_PORT_CONTROL, 32'h14, `XFER_8, lc);
      lag = 8'hff;
      nb = irqs;
      v = $random(seed);
      wq.push_back({1'b0, v[7:0]});
      acc(1'b1, `OFS_EPP_EPP_DATA_BYTE0, v, `XFER_8, lc);
      check("timeout irq", nb + 1, irqs);
      check("timeout length", 1, lc >= TMO && lc <= TMO + 3);
      rd(`OFS_PORT_STATUS, `XFER_8, stat(1'b1), '1);
      rd(`OFS_PORT_STATUS, `XFER_8, stat(1'b0), '1);
      check("queues drained", 0, wq.size() + rq.size());
      end_sim();
   end
endmodule : tb
